/* lfsc_pkg.sv */
// Package: register map, state codes and timing for the linefeed state control block
package lfsc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATE   = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h08;
  localparam logic [7:0] ADDR_IRQCLR  = 8'h0C;
  localparam logic [7:0] ADDR_IRQEN   = 8'h10;
  localparam logic [7:0] ADDR_CONFIG  = 8'h14;
  localparam logic [7:0] ADDR_LCTHR   = 8'h18;
  localparam logic [7:0] ADDR_VTIP    = 8'h20;
  localparam logic [7:0] ADDR_VRING   = 8'h24;
  localparam logic [7:0] ADDR_VBAT    = 8'h28;
  localparam logic [7:0] ADDR_ITIP    = 8'h2C;
  localparam logic [7:0] ADDR_IRING   = 8'h30;
  localparam logic [7:0] ADDR_IBAT    = 8'h34;
  localparam logic [7:0] ADDR_VLOOP   = 8'h38;
  localparam logic [7:0] ADDR_ILOOP   = 8'h3C;
  localparam logic [7:0] ADDR_ILONG   = 8'h40;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int STATE_W     = 4;
  localparam int MEAS_W      = 16;
  localparam int IRQ_W       = 2;
  localparam int IRQ_PALARM  = 0;
  localparam int IRQ_LOOP    = 1;
  localparam int CFG_TJHI    = 0;
  localparam int CFG_OFFSET  = 1;
  localparam int CFG_DEB_LSB = 8;
  localparam int DEB_W       = 8;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0401;
  localparam logic [31:0] LCTHR_RST  = 32'h0200_0100;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int MON_RATE_HZ   = 2_000;
  localparam int MON_CYCLES    = CLK_HZ / MON_RATE_HZ;
  localparam int TSD_HOLD_MS   = 100;
  localparam int TSD_HOLD_CYC  = TSD_HOLD_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Linefeed states
  // ----------------------------------------------------------------
  typedef enum logic [STATE_W-1:0] {
    LF_OPEN,
    LF_FWD_ACTIVE,
    LF_REV_ACTIVE,
    LF_FWD_ON_HOOK_TX,
    LF_REV_ON_HOOK_TX,
    LF_TIP_OPEN,
    LF_RING_OPEN,
    LF_RINGING,
    LF_DIAG
  } lfsc_state_e;

endpackage

/* lfsc_top.sv */
// Linefeed state control with fault protection, monitoring registers and APB slave
// Functional notes
// - Nine selectable linefeed states, written through the state register.
// - Reset leaves the line in the open state.
// - Open state: leads high impedance, supervision and audio powered down.
// - Any fault forces open and sets the power alarm flag.
// - Power alarm interrupt is maskable; the protective move to open is not.
// - Fault sources: total power, foreign current or voltage, thermal shutdown.
// - Over junction_temp_limit (145 or 200 C) the device shuts down itself.
// - Thermal shutdown is held for a fixed delay after the heat clears.
// - Monitor registers refresh at 2 kHz or faster.
// - Loop voltage, loop current, longitudinal current computed and stored.
// - Active states feed line, audio, loop and ground key detect, with polarity.
// - On-hook transmission states feed line and audio, with polarity.
// - Tip open feeds ring only, tip high impedance, detectors active.
// - Ring open feeds tip only, ring high impedance, detectors active.
// - Ringing drives both leads, dc offset as configured.
// - Diagnostic state enables the diagnostic resources.
// - Loop closure uses two thresholds, debounce, status bit, maskable interrupt.
module lfsc_top #(
  parameter int TSD_HOLD = lfsc_pkg::TSD_HOLD_CYC,
  parameter int MON_DIV  = lfsc_pkg::MON_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Fault sensors
  input  wire logic                        overPower,
  input  wire logic                        foreignTip,
  input  wire logic                        foreignRing,
  input  wire logic                        dieOverLow,
  input  wire logic                        dieOverHigh,
  // Monitor converter samples
  input  wire logic [lfsc_pkg::MEAS_W-1:0] adcVtip,
  input  wire logic [lfsc_pkg::MEAS_W-1:0] adcVring,
  input  wire logic [lfsc_pkg::MEAS_W-1:0] adcVbat,
  input  wire logic [lfsc_pkg::MEAS_W-1:0] adcItip,
  input  wire logic [lfsc_pkg::MEAS_W-1:0] adcIring,
  input  wire logic [lfsc_pkg::MEAS_W-1:0] adcIbat,
  // Linefeed controls
  output logic                             tipDrive,
  output logic                             ringDrive,
  output logic                             reversePol,
  output logic                             audioEn,
  output logic                             superEn,
  output logic                             ringingEn,
  output logic                             ringOffsetEn,
  output logic                             diagEn,
  output logic                             thermalShutdown,
  output logic                             irq
);
  import lfsc_pkg::*;

  // Measurement slots and loop threshold layout
  localparam int MEAS_N     = 9;
  localparam int IDX_ILOOP  = 7;
  localparam int THR_ON_LSB = 16;

  // Refuse timing values the counters cannot serve
  if (TSD_HOLD < 1 || MON_DIV < 1 || MON_DIV > MON_CYCLES) begin : gBadParams
    $error("lfsc_top: bad timing parameters");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  lfsc_state_e          state_r;
  logic [IRQ_W-1:0]     irqStat_r;
  logic [IRQ_W-1:0]     irqEn_r;
  logic [31:0]          config_r;
  logic [31:0]          lcThr_r;
  logic [MEAS_W-1:0]    meas_r [MEAS_N];
  logic [31:0]          tsdCnt_r;
  logic [31:0]          monCnt_r;
  logic                 loopRaw_r;
  logic                 loopDet_r;
  logic [DEB_W-1:0]     debCnt_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        wrEn      = psel && penable && pwrite;
  wire        rdEn      = psel && !penable && !pwrite;
  wire        wrState   = wrEn && paddr == ADDR_STATE;
  wire        wrClr     = wrEn && paddr == ADDR_IRQCLR;
  wire        wrIrqEn   = wrEn && paddr == ADDR_IRQEN;
  wire        wrConfig  = wrEn && paddr == ADDR_CONFIG;
  wire        wrLcThr   = wrEn && paddr == ADDR_LCTHR;
  wire        stateOk   = pwdata[STATE_W-1:0] <= STATE_W'(LF_DIAG);
  wire        measHit   = paddr >= ADDR_VTIP && paddr <= ADDR_ILONG && paddr[1:0] == 2'b00;
  wire [3:0]  measIdx   = 4'((paddr - ADDR_VTIP) >> 2);
  wire        mapped    = paddr == ADDR_STATE || paddr == ADDR_STATUS || paddr == ADDR_IRQSTAT
                       || paddr == ADDR_IRQCLR || paddr == ADDR_IRQEN || paddr == ADDR_CONFIG
                       || paddr == ADDR_LCTHR || measHit;

  // ----------------------------------------------------------------
  // Fault detection and thermal hold
  // ----------------------------------------------------------------
  wire dieHot     = config_r[CFG_TJHI] ? dieOverHigh : dieOverLow;
  wire tsdActive  = dieHot || tsdCnt_r != 32'h0000_0000;
  wire fault      = overPower || foreignTip || foreignRing || tsdActive;

  // ----------------------------------------------------------------
  // Loop closure detection
  // ----------------------------------------------------------------
  wire [MEAS_W-1:0] iLoop   = meas_r[IDX_ILOOP];
  wire              lcAbove = iLoop > lcThr_r[THR_ON_LSB +: MEAS_W];
  wire              lcBelow = iLoop < lcThr_r[MEAS_W-1:0];
  wire              lcRaw   = lcAbove ? 1'b1 : (lcBelow ? 1'b0 : loopRaw_r);
  wire              lcDone  = debCnt_r == config_r[CFG_DEB_LSB +: DEB_W];
  wire              lcEvent = lcDone && loopRaw_r != loopDet_r;
  wire              detOn   = state_r inside {LF_FWD_ACTIVE, LF_REV_ACTIVE, LF_TIP_OPEN, LF_RING_OPEN};

  // ----------------------------------------------------------------
  // State and flag next values
  // ----------------------------------------------------------------
  wire lfsc_state_e stateNxt = fault ? LF_OPEN :
                               (wrState && stateOk) ? lfsc_state_e'(pwdata[STATE_W-1:0]) :
                               state_r;
  wire [IRQ_W-1:0] events   = {lcEvent && detOn, fault};
  wire [IRQ_W-1:0] irqNxt   = (irqStat_r & ~(wrClr ? pwdata[IRQ_W-1:0] : '0)) | events;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= LF_OPEN;
      irqStat_r <= '0;
      irqEn_r   <= '0;
      config_r  <= CONFIG_RST;
      lcThr_r   <= LCTHR_RST;
    end else begin
      state_r   <= stateNxt;
      irqStat_r <= irqNxt;
      if (wrIrqEn) begin
        irqEn_r <= pwdata[IRQ_W-1:0];
      end
      if (wrConfig) begin
        config_r <= pwdata;
      end
      if (wrLcThr) begin
        lcThr_r <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Thermal hold counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsdCnt_r <= '0;
    end else if (dieHot) begin
      tsdCnt_r <= 32'(TSD_HOLD);
    end else if (tsdCnt_r != 32'h0000_0000) begin
      tsdCnt_r <= tsdCnt_r - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Debounce filter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loopRaw_r <= 1'b0;
      loopDet_r <= 1'b0;
      debCnt_r  <= '0;
    end else begin
      loopRaw_r <= lcRaw;
      if (lcRaw != loopRaw_r || loopRaw_r == loopDet_r) begin
        debCnt_r <= '0;
      end else if (lcDone) begin
        loopDet_r <= loopRaw_r;
        debCnt_r  <= '0;
      end else begin
        debCnt_r <= debCnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Monitor refresh
  // ----------------------------------------------------------------
  wire                  monTick = monCnt_r == 32'(MON_DIV - 1);
  wire [MEAS_W-1:0]     calc [MEAS_N];
  assign calc[0] = adcVtip;
  assign calc[1] = adcVring;
  assign calc[2] = adcVbat;
  assign calc[3] = adcItip;
  assign calc[4] = adcIring;
  assign calc[5] = adcIbat;
  assign calc[6] = adcVtip - adcVring;
  assign calc[7] = MEAS_W'((17'(adcItip) + 17'(adcIring)) >> 1);
  assign calc[8] = MEAS_W'((17'(adcItip) - 17'(adcIring)) >> 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      monCnt_r <= '0;
    end else begin
      monCnt_r <= monTick ? '0 : monCnt_r + 32'h0000_0001;
    end
  end

  genvar g;
  generate
    for (g = 0; g < MEAS_N; g++) begin : gMeas
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meas_r[g] <= '0;
        end else if (monTick) begin
          meas_r[g] <= calc[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line controls per state
  // ----------------------------------------------------------------
  logic tipNxt, ringNxt, revNxt, audNxt, supNxt, rngNxt, diagNxt;
  always_comb begin
    tipNxt  = 1'b0;
    ringNxt = 1'b0;
    revNxt  = 1'b0;
    audNxt  = 1'b0;
    supNxt  = 1'b0;
    rngNxt  = 1'b0;
    diagNxt = 1'b0;
    unique case (stateNxt)
      LF_OPEN: begin
      end
      LF_FWD_ACTIVE, LF_REV_ACTIVE: begin
        tipNxt  = 1'b1;
        ringNxt = 1'b1;
        audNxt  = 1'b1;
        supNxt  = 1'b1;
        revNxt  = stateNxt == LF_REV_ACTIVE;
      end
      LF_FWD_ON_HOOK_TX, LF_REV_ON_HOOK_TX: begin
        tipNxt  = 1'b1;
        ringNxt = 1'b1;
        audNxt  = 1'b1;
        revNxt  = stateNxt == LF_REV_ON_HOOK_TX;
      end
      LF_TIP_OPEN: begin
        ringNxt = 1'b1;
        supNxt  = 1'b1;
      end
      LF_RING_OPEN: begin
        tipNxt  = 1'b1;
        supNxt  = 1'b1;
        revNxt  = 1'b1;
      end
      LF_RINGING: begin
        tipNxt  = 1'b1;
        ringNxt = 1'b1;
        rngNxt  = 1'b1;
      end
      LF_DIAG: begin
        diagNxt = 1'b1;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tipDrive        <= 1'b0;
      ringDrive       <= 1'b0;
      reversePol      <= 1'b0;
      audioEn         <= 1'b0;
      superEn         <= 1'b0;
      ringingEn       <= 1'b0;
      ringOffsetEn    <= 1'b0;
      diagEn          <= 1'b0;
      thermalShutdown <= 1'b0;
      irq             <= 1'b0;
    end else begin
      tipDrive        <= tipNxt;
      ringDrive       <= ringNxt;
      reversePol      <= revNxt;
      audioEn         <= audNxt;
      superEn         <= supNxt;
      ringingEn       <= rngNxt;
      ringOffsetEn    <= rngNxt && config_r[CFG_OFFSET];
      diagEn          <= diagNxt;
      thermalShutdown <= tsdActive;
      irq             <= |(irqNxt & (wrIrqEn ? pwdata[IRQ_W-1:0] : irqEn_r));
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (1'b1)
      paddr == ADDR_STATE:   rdMux = 32'(state_r);
      paddr == ADDR_STATUS:  rdMux = {29'h0, loopDet_r, tsdActive, fault};
      paddr == ADDR_IRQSTAT: rdMux = 32'(irqStat_r);
      paddr == ADDR_IRQEN:   rdMux = 32'(irqEn_r);
      paddr == ADDR_CONFIG:  rdMux = config_r;
      paddr == ADDR_LCTHR:   rdMux = lcThr_r;
      measHit:               rdMux = 32'(meas_r[measIdx]);
      default:               rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rdEn) begin
        prdata <= rdMux;
      end
    end
  end

endmodule

/* lfsc_checker.sv */
// Checker: port-level properties of the linefeed state control block
module lfsc_checker #(
  parameter int TSD_HOLD = lfsc_pkg::TSD_HOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Faults
  input wire logic overPower,
  input wire logic foreignTip,
  input wire logic foreignRing,
  input wire logic dieOverLow,
  input wire logic dieOverHigh,
  // Line controls
  input wire logic tipDrive,
  input wire logic ringDrive,
  input wire logic audioEn,
  input wire logic superEn,
  input wire logic ringingEn,
  input wire logic diagEn,
  input wire logic thermalShutdown
);
  logic        fault;
  logic        lineOff;
  logic [31:0] coolCnt_r;
  assign fault   = overPower | foreignTip | foreignRing;
  assign lineOff = !tipDrive && !ringDrive && !audioEn && !superEn;
  // Cycles since the die was last hot
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) coolCnt_r <= '0;
    else if (dieOverLow | dieOverHigh) coolCnt_r <= '0;
    else if (coolCnt_r != 32'hFFFF_FFFF) coolCnt_r <= coolCnt_r + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence faultHeld; fault ##1 fault; endsequence
  sequence hotHeld; dieOverHigh ##1 dieOverHigh; endsequence
  sequence setupPhase; psel && !penable; endsequence
  fault_open_a: assert property (faultHeld |-> ##1 lineOff)
    else $error("line not opened on fault");
  tsd_rise_a: assert property (hotHeld |-> thermalShutdown)
    else $error("no thermal shutdown when hot");
  tsd_off_a: assert property (thermalShutdown ##1 thermalShutdown |-> !tipDrive && !ringDrive)
    else $error("leads fed in thermal shutdown");
  tsd_hold_a: assert property ($fell(thermalShutdown) |-> coolCnt_r >= TSD_HOLD - 1)
    else $error("thermal shutdown released early");
  ring_both_a: assert property (ringingEn |-> tipDrive && ringDrive)
    else $error("ringing without both leads");
  open_quiet_a: assert property (!tipDrive && !ringDrive && !ringingEn && !diagEn |-> !audioEn && !superEn)
    else $error("open state not powered down");
  ready_one_a: assert property (setupPhase |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
bind lfsc_top lfsc_checker #(.TSD_HOLD(TSD_HOLD)) chk (.clk, .nrst, .psel, .penable, .pready, .pslverr,
  .overPower, .foreignTip, .foreignRing, .dieOverLow, .dieOverHigh, .tipDrive, .ringDrive,
  .audioEn, .superEn, .ringingEn, .diagEn, .thermalShutdown);

/* lfsc_line_model.sv */
// Partner model: analog line seen through the monitor converter
module lfsc_line_model (
  // Hook switch of the far-end set
  input  wire logic                        offHook,
  // Converter samples
  output logic      [lfsc_pkg::MEAS_W-1:0] adcVtip,
  output logic      [lfsc_pkg::MEAS_W-1:0] adcVring,
  output logic      [lfsc_pkg::MEAS_W-1:0] adcVbat,
  output logic      [lfsc_pkg::MEAS_W-1:0] adcItip,
  output logic      [lfsc_pkg::MEAS_W-1:0] adcIring,
  output logic      [lfsc_pkg::MEAS_W-1:0] adcIbat
);
  import lfsc_pkg::*;
  // Off-hook set draws loop current
  assign adcVtip  = 16'h3000;
  assign adcVring = 16'h1000;
  assign adcVbat  = 16'h4800;
  assign adcItip  = offHook ? 16'h0500 : 16'h0010;
  assign adcIring = offHook ? 16'h0300 : 16'h0010;
  assign adcIbat  = 16'h0050;
endmodule

/* linefeed_state_control_test.sv */
// Testbench: scenarios for the linefeed state control block
module linefeed_state_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lfsc_pkg::*;
  localparam int TSDH = 20;
  localparam int MDIV = 8;
  logic              clk, nrst, psel, penable, pwrite, pready, pslverr, errv, offHook, irq;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic              overPower, foreignTip, foreignRing, dieOverLow, dieOverHigh;
  logic [MEAS_W-1:0] adcVtip, adcVring, adcVbat, adcItip, adcIring, adcIbat;
  logic              tipDrive, ringDrive, reversePol, audioEn, superEn, ringingEn;
  logic              ringOffsetEn, diagEn, thermalShutdown;
  logic [6:0]        lineOut;
  int                miscompares, nChecks;
  logic [6:0]        expTab [9] = '{7'h00, 7'h6C, 7'h7C, 7'h68, 7'h78, 7'h24, 7'h54, 7'h62, 7'h01};
  logic [6:0]        mskTab [9] = '{7'h7F, 7'h7F, 7'h7F, 7'h7B, 7'h7B, 7'h77, 7'h77, 7'h63, 7'h01};
  logic [15:0]       expMeas [9] = '{16'h3000, 16'h1000, 16'h4800, 16'h0500, 16'h0300, 16'h0050,
                                     16'h2000, 16'h0400, 16'h0100};
  assign lineOut = {tipDrive, ringDrive, reversePol, audioEn, superEn, ringingEn, diagEn};
  lfsc_top #(.TSD_HOLD(TSDH), .MON_DIV(MDIV)) DUT (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .overPower, .foreignTip, .foreignRing, .dieOverLow,
    .dieOverHigh, .adcVtip, .adcVring, .adcVbat, .adcItip, .adcIring, .adcIbat, .tipDrive,
    .ringDrive, .reversePol, .audioEn, .superEn, .ringingEn, .ringOffsetEn, .diagEn,
    .thermalShutdown, .irq);
  lfsc_line_model line (.offHook, .adcVtip, .adcVring, .adcVbat, .adcItip, .adcIring, .adcIbat);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) miscompares++;
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tReset;
    chk("lines after reset", 7'h00, lineOut);
    apb(1'b0, ADDR_STATE, 32'h0);
    chk("state after reset", 32'h0, rdv[3:0]);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config", CONFIG_RST, rdv);
    chk("mapped no error", 32'h0, errv);
    apb(1'b0, ADDR_LCTHR, 32'h0);
    chk("thresholds", LCTHR_RST, rdv);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped error", 32'h1, errv);
    $display("tReset finished");
  endtask
  task automatic tStates;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, ADDR_STATE, i);
      tick(2);
      chk("line controls", expTab[i], lineOut & mskTab[i]);
      apb(1'b0, ADDR_STATE, 32'h0);
      chk("state readback", i, rdv[3:0]);
    end
    apb(1'b1, ADDR_STATE, 32'h9);
    apb(1'b0, ADDR_STATE, 32'h0);
    chk("bad state ignored", 32'h8, rdv[3:0]);
    apb(1'b1, ADDR_STATE, LF_RINGING);
    apb(1'b1, ADDR_CONFIG, CONFIG_RST | 32'h2);
    tick(2);
    chk("ringing offset", 32'h1, ringOffsetEn);
    apb(1'b1, ADDR_CONFIG, CONFIG_RST);
    $display("tStates finished");
  endtask
  task automatic tFault;
    apb(1'b1, ADDR_IRQEN, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_STATE, LF_FWD_ACTIVE);
      @(posedge clk) {overPower, foreignTip, foreignRing} <= 3'b100 >> i;
      tick(3);
      chk("fault lines", 7'h00, lineOut);
      chk("alarm irq", 32'h1, irq);
      apb(1'b1, ADDR_STATE, LF_REV_ACTIVE);
      tick(2);
      chk("write during fault", 32'h0, tipDrive);
      @(posedge clk) {overPower, foreignTip, foreignRing} <= 3'b000;
      tick(3);
      chk("alarm sticky", 32'h1, irq);
      apb(1'b1, ADDR_IRQCLR, 32'h1);
      tick(2);
      chk("alarm cleared", 32'h0, irq);
    end
    apb(1'b1, ADDR_IRQEN, 32'h0);
    @(posedge clk) overPower <= 1'b1;
    @(posedge clk) overPower <= 1'b0;
    tick(3);
    chk("masked irq", 32'h0, irq);
    apb(1'b0, ADDR_IRQSTAT, 32'h0);
    chk("masked flag", 32'h1, rdv[IRQ_PALARM]);
    apb(1'b1, ADDR_IRQCLR, 32'h3);
    $display("tFault finished");
  endtask
  task automatic tThermal;
    apb(1'b1, ADDR_STATE, LF_FWD_ACTIVE);
    @(posedge clk) dieOverLow <= 1'b1;
    tick(4);
    chk("below selected limit", 32'h0, thermalShutdown);
    @(posedge clk) dieOverHigh <= 1'b1;
    tick(3);
    chk("shutdown", 32'h1, thermalShutdown);
    chk("shutdown leads", 32'h0, tipDrive | ringDrive);
    @(posedge clk) {dieOverLow, dieOverHigh} <= 2'b00;
    tick(TSDH - 4);
    chk("shutdown held", 32'h1, thermalShutdown);
    tick(12);
    chk("shutdown released", 32'h0, thermalShutdown);
    apb(1'b0, ADDR_IRQSTAT, 32'h0);
    chk("thermal alarm", 32'h1, rdv[IRQ_PALARM]);
    apb(1'b1, ADDR_CONFIG, CONFIG_RST & ~32'h1);
    @(posedge clk) dieOverLow <= 1'b1;
    tick(3);
    chk("lower limit", 32'h1, thermalShutdown);
    @(posedge clk) dieOverLow <= 1'b0;
    tick(TSDH + 8);
    apb(1'b1, ADDR_CONFIG, CONFIG_RST);
    apb(1'b1, ADDR_IRQCLR, 32'h3);
    $display("tThermal finished");
  endtask
  task automatic tMonitor;
    apb(1'b1, ADDR_STATE, LF_FWD_ACTIVE);
    apb(1'b1, ADDR_IRQEN, 32'h2);
    @(posedge clk) offHook <= 1'b1;
    tick(2 * MDIV + 40);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ADDR_VTIP + 8'(4 * i), 32'h0);
      chk("measurement", expMeas[i], rdv[15:0]);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("loop status", 32'h1, rdv[2]);
    chk("loop irq", 32'h1, irq);
    @(posedge clk) offHook <= 1'b0;
    tick(2 * MDIV + 40);
    apb(1'b0, ADDR_ITIP, 32'h0);
    chk("refreshed sample", 32'h0010, rdv[15:0]);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("loop released", 32'h0, rdv[2]);
    $display("tMonitor finished");
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, offHook} = '0;
    {overPower, foreignTip, foreignRing, dieOverLow, dieOverHigh} = '0;
    miscompares = 0;
    nChecks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tReset;
    tStates;
    tFault;
    tThermal;
    tMonitor;
    @(posedge clk) nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tReset;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
